// File: src/motor_run_logic.sv
// Run, direction, speed-reached and load holding logic of the motor driver
module motor_run_logic
  import motor_run_pkg::*;
#(
  parameter int SPEED_W = 16
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_update,
  input wire logic i_forward_run_input,
  input wire logic i_reverse_run_input,
  input wire logic i_run_direction_input,
  input wire logic i_start_input,
  input wire logic i_stop_input,
  input wire logic i_alarm,
  input wire logic i_power_ok,
  input wire logic signed [SPEED_W-1:0] i_measured_speed,
  input wire logic [SPEED_W-1:0] i_set_speed,
  input wire logic [7:0] i_data_torque_limit,
  input wire logic signed [7:0] i_shaft_offset,
  output logic signed [SPEED_W-1:0] o_speed_command,
  output logic o_run,
  output logic o_dir_cw,
  output logic [1:0] o_stop_mode,
  output logic o_speed_reached_output,
  output logic o_hold_active,
  output logic [7:0] o_hold_torque_limit,
  output logic o_irq
);
  function automatic logic [SPEED_W-1:0] abs_val(input logic signed [SPEED_W-1:0] v);
    abs_val = v[SPEED_W-1] ? SPEED_W'(-v) : SPEED_W'(v);
  endfunction : abs_val

  // Pin synchronisers
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {i_power_ok, i_alarm, i_stop_input, i_start_input,
                  i_run_direction_input, i_reverse_run_input, i_forward_run_input};
      sync2_q <= sync1_q;
    end
  end
  logic fwd_s, rev_s, rdir_s, start_s, stop_s, alarm_s, power_s;
  assign {power_s, alarm_s, stop_s, start_s, rdir_s, rev_s, fwd_s} = sync2_q;

  // Pending settings and applied copies
  logic [1:0] filter_p_q, filter_q;
  logic [1:0] stop_p_q, stop_q;
  logic dir_p_q, dir_q;
  logic mode_p_q, mode_q;
  logic hold_en_p_q, hold_en_q;
  logic [8:0] width_q;
  logic signed [7:0] hold_lim_q;
  logic [2:0] int_status_q, int_mask_q;
  logic config_pulse;
  run_state_t state_q;
  logic stopped;
  assign stopped = (state_q == RUN_STOPPED);
  assign config_pulse = i_wr && i_addr == ADDR_CONFIG && i_wdata[0];

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      filter_p_q <= FILTER_NONE;
      stop_p_q <= STOP_MODE_1;
      dir_p_q <= DIR_POS_CW;
      mode_p_q <= MODE_3WIRE;
      hold_en_p_q <= 1'b0;
      width_q <= WIDTH_RESET;
      hold_lim_q <= HOLD_FOLLOW;
      int_mask_q <= '0;
    end else if (i_wr) begin
      unique case (i_addr)
        ADDR_FILTER: if (i_wdata[1:0] <= FILTER_TWO) filter_p_q <= i_wdata[1:0];
        ADDR_STOP_MODE: if (i_wdata[1:0] <= STOP_MODE_3) stop_p_q <= i_wdata[1:0];
        ADDR_DIRECTION: dir_p_q <= i_wdata[0];
        ADDR_INPUT_MODE: mode_p_q <= i_wdata[0];
        ADDR_HOLD_EN: hold_en_p_q <= i_wdata[0];
        ADDR_WIDTH: begin
          // Out-of-range widths are ignored, not clamped
          if (i_wdata[8:0] >= WIDTH_MIN && i_wdata[8:0] <= WIDTH_MAX && i_wdata[15:9] == '0)
            width_q <= i_wdata[8:0];
        end
        ADDR_HOLD_LIMIT: begin
          if ($signed(i_wdata[7:0]) >= HOLD_FOLLOW && $signed(i_wdata[7:0]) <= $signed(HOLD_CAP))
            hold_lim_q <= i_wdata[7:0];
        end
        ADDR_INT_MASK: int_mask_q <= i_wdata[2:0];
        default: ;
      endcase
    end
  end

  // Update class B applies at stop, class C on configuration
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      filter_q <= FILTER_NONE;
      stop_q <= STOP_MODE_1;
    end else if (stopped) begin
      filter_q <= filter_p_q;
      stop_q <= stop_p_q;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      dir_q <= DIR_POS_CW;
      mode_q <= MODE_3WIRE;
      hold_en_q <= 1'b0;
    end else if (config_pulse) begin
      dir_q <= dir_p_q;
      mode_q <= mode_p_q;
      hold_en_q <= hold_en_p_q;
    end
  end

  // Input decoding
  logic run_req, run_positive;
  logic run3_q;
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      run3_q <= 1'b0;
    end else if (stop_s) begin
      run3_q <= 1'b0;
    end else if (start_s) begin
      run3_q <= 1'b1;
    end
  end

  always_comb begin
    if (mode_q == MODE_3WIRE) begin
      run_req = run3_q;
      run_positive = rdir_s;
    end else begin
      // Both inputs on counts as stop in 2-wire mode
      run_req = fwd_s ^ rev_s;
      run_positive = fwd_s;
    end
  end

  logic dir_cw_d;
  assign dir_cw_d = (dir_q == DIR_POS_CW) ? run_positive : !run_positive;

  logic signed [SPEED_W-1:0] target;
  logic signed [SPEED_W-1:0] smoothed;
  assign target = (run_req && !alarm_s && power_s) ?
                  (dir_cw_d ? $signed(i_set_speed) : -$signed(i_set_speed)) : '0;

  ramp_soften #(
    .WIDTH(SPEED_W)
  ) u_soften (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_update(i_update),
    .i_filter(filter_q),
    .i_target(target),
    .o_smoothed(smoothed)
  );

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_q <= RUN_STOPPED;
    end else begin
      unique case (state_q)
        RUN_STOPPED: if (run_req) state_q <= RUN_MOVING;
        RUN_MOVING: if (!run_req && smoothed == '0) state_q <= RUN_STOPPED;
      endcase
    end
  end

  // Speed-reached compare
  logic reached_q;
  logic [SPEED_W-1:0] err;
  assign err = abs_val(i_measured_speed - smoothed);
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      reached_q <= 1'b0;
    end else if (i_update) begin
      reached_q <= run_req && (err <= SPEED_W'(width_q));
    end
  end

  // Load holding
  logic hold_q;
  logic [7:0] hold_tq_q;
  logic [7:0] lim_src;
  logic [7:0] offs_abs;
  assign lim_src = (hold_lim_q == HOLD_FOLLOW) ? i_data_torque_limit : hold_lim_q;
  assign offs_abs = i_shaft_offset[7] ? 8'(-i_shaft_offset) : 8'(i_shaft_offset);
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      hold_q <= 1'b0;
      hold_tq_q <= '0;
    end else begin
      // Holding extends settle time; standstill judged from ramp only
      hold_q <= hold_en_q && stopped && !alarm_s && power_s;
      if (hold_en_q && stopped && !alarm_s && power_s && offs_abs >= HOLD_ANGLE) begin
        hold_tq_q <= (lim_src > HOLD_CAP) ? HOLD_CAP : lim_src;
      end else begin
        hold_tq_q <= '0;
      end
    end
  end

  // Outputs and interrupts
  logic reached_out_q, hold_out_q;
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_speed_command <= '0;
      o_run <= 1'b0;
      o_dir_cw <= 1'b1;
      o_stop_mode <= STOP_MODE_1;
      reached_out_q <= 1'b0;
      hold_out_q <= 1'b0;
    end else begin
      o_speed_command <= smoothed;
      o_run <= !stopped;
      o_dir_cw <= dir_cw_d;
      o_stop_mode <= stop_q;
      reached_out_q <= reached_q;
      hold_out_q <= hold_q;
    end
  end
  assign o_speed_reached_output = reached_out_q;
  assign o_hold_active = hold_out_q;
  assign o_hold_torque_limit = hold_tq_q;

  logic [2:0] events;
  assign events = {config_pulse, hold_out_q && !hold_q, reached_q && !reached_out_q};
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      int_status_q <= '0;
    end else begin
      // Set wins over a same-cycle clear
      int_status_q <= (int_status_q & ~((i_wr && i_addr == ADDR_INT_STATUS) ?
                       i_wdata[2:0] : 3'h0)) | events;
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(int_status_q & int_mask_q);
    end
  end

  // Register read port
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      unique case (i_addr)
        ADDR_FILTER: o_rdata <= {14'h0, filter_p_q};
        ADDR_STOP_MODE: o_rdata <= {14'h0, stop_p_q};
        ADDR_DIRECTION: o_rdata <= {15'h0, dir_p_q};
        ADDR_INPUT_MODE: o_rdata <= {15'h0, mode_p_q};
        ADDR_WIDTH: o_rdata <= {7'h0, width_q};
        ADDR_HOLD_EN: o_rdata <= {15'h0, hold_en_p_q};
        ADDR_HOLD_LIMIT: o_rdata <= {{8{hold_lim_q[7]}}, hold_lim_q};
        ADDR_STATUS: o_rdata <= {12'h0, hold_q, reached_q, dir_cw_d, !stopped};
        ADDR_INT_STATUS: o_rdata <= {13'h0, int_status_q};
        ADDR_INT_MASK: o_rdata <= {13'h0, int_mask_q};
        ADDR_ACTIVE: o_rdata <= {10'h0, hold_en_q, mode_q, dir_q, stop_q, filter_q[0]};
        default: o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end
endmodule : motor_run_logic

// File: common/motor_run_pkg.sv
// Package of constants for the motor run parameter logic
// Behaviour
// - Softening filter: none, first, second; default none
// - Active filter smooths ramps, stretching durations
// - Three stop modes, first default, after stop
// - Direction polarity fixes forward/run-direction rotation
// - Two-wire or three-wire input mode, three default
// - Speed-reached high within width of command
// - Width 1 to 400 r/min, default 200, immediate
// - Load holding gives standstill torque when enabled
// - Holding force once shaft displaced about 15 degrees
// - Limit of minus one follows operation data
// - Holding torque clamped to at most 50 percent
// - Limit 0 to 50 applied directly
// - Alarm or power loss drops holding force
// - Holding may lengthen time to standstill
// - Updates: immediate, after stop, after configuration
package motor_run_pkg;
  localparam logic [3:0] ADDR_FILTER = 4'h0;
  localparam logic [3:0] ADDR_STOP_MODE = 4'h1;
  localparam logic [3:0] ADDR_DIRECTION = 4'h2;
  localparam logic [3:0] ADDR_INPUT_MODE = 4'h3;
  localparam logic [3:0] ADDR_WIDTH = 4'h4;
  localparam logic [3:0] ADDR_HOLD_EN = 4'h5;
  localparam logic [3:0] ADDR_HOLD_LIMIT = 4'h6;
  localparam logic [3:0] ADDR_CONFIG = 4'h7;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_INT_STATUS = 4'h9;
  localparam logic [3:0] ADDR_INT_MASK = 4'ha;
  localparam logic [3:0] ADDR_ACTIVE = 4'hb;
  localparam logic [1:0] FILTER_NONE = 2'h0;
  localparam logic [1:0] FILTER_ONE = 2'h1;
  localparam logic [1:0] FILTER_TWO = 2'h2;
  localparam logic [1:0] STOP_MODE_1 = 2'h0;
  localparam logic [1:0] STOP_MODE_3 = 2'h2;
  localparam logic DIR_POS_CW = 1'b0;
  localparam logic MODE_3WIRE = 1'b1;
  localparam logic [8:0] WIDTH_MIN = 9'h001;
  localparam logic [8:0] WIDTH_MAX = 9'h190;
  localparam logic [8:0] WIDTH_RESET = 9'h0c8;
  localparam logic signed [7:0] HOLD_FOLLOW = -8'sd1;
  localparam logic [7:0] HOLD_CAP = 8'h32;
  localparam logic [7:0] HOLD_ANGLE = 8'h0f;
  localparam int INT_SPEED_REACHED = 0;
  localparam int INT_HOLD_LOST = 1;
  localparam int INT_CONFIG_DONE = 2;
  localparam int RAMP_SHIFT_ONE = 2;
  localparam int RAMP_SHIFT_TWO = 4;
  typedef enum logic [1:0] {
    RUN_STOPPED = 2'b01,
    RUN_MOVING = 2'b10
  } run_state_t;
endpackage : motor_run_pkg

// File: src/ramp_soften.sv
// First-order smoothing of the commanded speed ramp
module ramp_soften
  import motor_run_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_update,
  input wire logic [1:0] i_filter,
  input wire logic signed [WIDTH-1:0] i_target,
  output logic signed [WIDTH-1:0] o_smoothed
);
  logic signed [WIDTH+3:0] acc_q;
  logic signed [WIDTH+3:0] diff;
  logic signed [WIDTH+3:0] step;

  always_comb begin
    diff = {{4{i_target[WIDTH-1]}}, i_target} - acc_q;
    if (i_filter == FILTER_ONE) begin
      step = diff >>> RAMP_SHIFT_ONE;
    end else if (i_filter == FILTER_TWO) begin
      step = diff >>> RAMP_SHIFT_TWO;
    end else begin
      step = diff;
    end
    // Never stall short of target on small residuals
    if (step == '0 && diff != '0) begin
      step = diff[WIDTH+3] ? {(WIDTH+4){1'b1}} : (WIDTH+4)'(1);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      acc_q <= '0;
    end else if (i_update) begin
      acc_q <= acc_q + step;
    end
  end

  assign o_smoothed = acc_q[WIDTH-1:0];
endmodule : ramp_soften

// File: verif/motor_far_side.sv
// Behavioural motor: speed follows the command with a set slip
module motor_far_side (
  input wire logic i_clock,
  input wire logic signed [15:0] i_speed_command,
  input wire logic [15:0] i_slip,
  input wire logic signed [7:0] i_twist,
  output logic signed [15:0] o_measured_speed,
  output logic signed [7:0] o_shaft_offset
);
  timeunit 1ns;
  timeprecision 1ns;
  // One sample of lag, like a real speed sensor
  always_ff @(posedge i_clock) begin
    o_measured_speed <= i_speed_command + $signed(i_slip);
  end
  assign o_shaft_offset = i_twist;
endmodule : motor_far_side

// File: verif/motor_run_chk.sv
// Port assertions for the motor run logic
module motor_run_chk
  import motor_run_pkg::*;
#(
  parameter int SPEED_W = 16
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [3:0] i_addr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic i_alarm,
  input wire logic i_power_ok,
  input wire logic signed [7:0] i_shaft_offset,
  input wire logic o_run,
  input wire logic [1:0] o_stop_mode,
  input wire logic o_speed_reached_output,
  input wire logic o_hold_active,
  input wire logic [7:0] o_hold_torque_limit,
  input wire logic o_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  a_hold_cap: assert property (o_hold_torque_limit <= HOLD_CAP)
    else $error("holding torque above cap");
  // Five cycles cover the two-flop sync plus the hold and output registers
  a_hold_alarm: assert property (i_alarm [*5] |=> !o_hold_active)
    else $error("holding kept during alarm");
  a_hold_power: assert property ((!i_power_ok) [*5] |=> !o_hold_active)
    else $error("holding kept without power");
  a_hold_angle: assert property ((i_shaft_offset > 8'shf1 && i_shaft_offset < 8'sh0f) [*4]
    |=> o_hold_torque_limit == 8'h00) else $error("holding torque below angle");
  a_hold_run: assert property (o_run && $past(o_run) |-> !o_hold_active)
    else $error("holding while running");
  a_stop_stopped: assert property ($changed(o_stop_mode) |-> !$past(o_run) || !$past(o_run, 2))
    else $error("stop mode changed while running");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data outside read cycle");
  a_unmapped_zero: assert property (i_rd && i_addr > ADDR_ACTIVE |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  c_reach: cover property (o_run && o_speed_reached_output);
  c_hold: cover property (o_hold_active && o_hold_torque_limit == HOLD_CAP);
  c_irq: cover property ($rose(o_irq));
endmodule : motor_run_chk

bind motor_run_logic motor_run_chk #(.SPEED_W(SPEED_W)) i_chk (.i_clock, .i_sys_rst, .i_addr,
  .i_rd, .o_rdata, .i_alarm, .i_power_ok, .i_shaft_offset, .o_run, .o_stop_mode,
  .o_speed_reached_output, .o_hold_active, .o_hold_torque_limit, .o_irq);

// File: verif/testbench.sv
// Self-checking bench for the motor run logic
module testbench
  import motor_run_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RUN = 0, CW = 1, STOPM = 2, REACH = 3, HOLD = 4, TORQ = 5, IRQ = 6, CMD = 7;
  logic i_clock = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_update = 1'b0;
  logic i_forward_run_input = 1'b0, i_reverse_run_input = 1'b0, i_run_direction_input = 1'b1;
  logic i_start_input = 1'b0, i_stop_input = 1'b0, i_alarm = 1'b0, i_power_ok = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000, i_set_speed = 16'h03e8, slip = 16'h00c8, o_rdata;
  logic [7:0] i_data_torque_limit = 8'h50, o_hold_torque_limit;
  logic signed [7:0] twist = 8'sh14, i_shaft_offset;
  logic signed [15:0] i_measured_speed, o_speed_command;
  logic o_run, o_dir_cw, o_speed_reached_output, o_hold_active, o_irq;
  logic [1:0] o_stop_mode;
  logic [15:0] rst_tab [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h00c8, 16'h0000};
  logic [15:0] w_in [5] = '{16'h0000, 16'h0190, 16'h0191, 16'h0001, 16'h00c8};
  logic [15:0] w_out [5] = '{16'h00c8, 16'h0190, 16'h0190, 16'h0001, 16'h00c8};
  int failures = 0, compares = 0, k;
  motor_run_logic #(.SPEED_W(16)) i_dut (.i_clock, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_update, .i_forward_run_input, .i_reverse_run_input, .i_run_direction_input,
    .i_start_input, .i_stop_input, .i_alarm, .i_power_ok, .i_measured_speed, .i_set_speed,
    .i_data_torque_limit, .i_shaft_offset, .o_speed_command, .o_run, .o_dir_cw, .o_stop_mode,
    .o_speed_reached_output, .o_hold_active, .o_hold_torque_limit, .o_irq);
  motor_far_side i_motor (.i_clock, .i_speed_command(o_speed_command), .i_slip(slip),
    .i_twist(twist), .o_measured_speed(i_measured_speed), .o_shaft_offset(i_shaft_offset));
  initial begin
    forever #25 i_clock = ~i_clock;
  end
  always @(posedge i_clock) i_update <= ~i_update;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge i_clock);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, v};
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_clock);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask : rd_chk
  function automatic logic [15:0] pick(input int s);
    logic [15:0] v [8];
    v = '{16'(o_run), 16'(o_dir_cw), 16'(o_stop_mode), 16'(o_speed_reached_output),
      16'(o_hold_active), 16'(o_hold_torque_limit), 16'(o_irq), 16'(o_speed_command)};
    return v[s];
  endfunction : pick
  // Bounded wait; running out is a mismatch and ends the run
  task automatic await(input int s, input logic [15:0] exp);
    // Look a step after the edge so outputs have settled
    #1;
    for (k = 0; k < 400 && pick(s) !== exp; k++) begin
      @(posedge i_clock);
      #1;
    end
    chk(pick(s), exp);
    if (k == 400) begin
      failures++;
      close_out();
    end
    // Hand back on an edge so the next pin change lands there
    @(posedge i_clock);
  endtask : await
  task automatic tap(input logic stop);
    @(posedge i_clock);
    {i_start_input, i_stop_input} <= {!stop, stop};
    repeat (3) @(posedge i_clock);
    {i_start_input, i_stop_input} <= 2'b00;
  endtask : tap
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (6) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    #1 chk(16'(o_dir_cw), 16'h0001);
    foreach (rst_tab[j]) rd_chk(4'(j), rst_tab[j]);
    rd_chk(4'hf, 16'h0000);
    for (int c = 2; c >= 0; c--) begin
      wr(ADDR_FILTER, 16'(c));
      wr(ADDR_STOP_MODE, 16'(c));
      wr(ADDR_FILTER, 16'h0003);
      wr(ADDR_STOP_MODE, 16'h0003);
      rd_chk(ADDR_FILTER, 16'(c));
      rd_chk(ADDR_STOP_MODE, 16'(c));
    end
    foreach (w_in[j]) begin
      wr(ADDR_WIDTH, w_in[j]);
      rd_chk(ADDR_WIDTH, w_out[j]);
    end
    $display("Test registers finished");
    wr(ADDR_INT_MASK, 16'h0001);
    tap(1'b0);
    await(RUN, 16'h0001);
    await(CW, 16'h0001);
    await(REACH, 16'h0001);
    await(IRQ, 16'h0001);
    wr(ADDR_INT_STATUS, 16'h0001);
    await(IRQ, 16'h0000);
    slip <= 16'h00c9;
    await(REACH, 16'h0000);
    wr(ADDR_WIDTH, 16'h0190);
    await(REACH, 16'h0001);
    wr(ADDR_STOP_MODE, 16'h0002);
    repeat (20) @(posedge i_clock);
    #1 chk(pick(STOPM), 16'h0000);
    tap(1'b1);
    await(RUN, 16'h0000);
    await(STOPM, 16'h0002);
    $display("Test three wire finished");
    wr(ADDR_INPUT_MODE, 16'h0000);
    wr(ADDR_FILTER, 16'h0001);
    wr(ADDR_CONFIG, 16'h0001);
    i_forward_run_input <= 1'b1;
    await(CMD, i_set_speed >> RAMP_SHIFT_ONE);
    await(RUN, 16'h0001);
    await(CW, 16'h0001);
    await(CMD, i_set_speed);
    {i_forward_run_input, i_reverse_run_input} <= 2'b01;
    await(CW, 16'h0000);
    await(RUN, 16'h0001);
    await(CMD, 16'(-i_set_speed));
    i_reverse_run_input <= 1'b0;
    await(RUN, 16'h0000);
    wr(ADDR_DIRECTION, 16'h0001);
    wr(ADDR_CONFIG, 16'h0001);
    i_forward_run_input <= 1'b1;
    await(RUN, 16'h0001);
    await(CW, 16'h0000);
    await(CMD, 16'(-i_set_speed));
    i_forward_run_input <= 1'b0;
    await(RUN, 16'h0000);
    $display("Test two wire finished");
    wr(ADDR_HOLD_EN, 16'h0001);
    wr(ADDR_CONFIG, 16'h0001);
    wr(ADDR_HOLD_LIMIT, 16'h001e);
    await(HOLD, 16'h0001);
    await(TORQ, 16'h001e);
    wr(ADDR_HOLD_LIMIT, 16'hffff);
    await(TORQ, 16'h0032);
    i_data_torque_limit <= 8'h28;
    await(TORQ, 16'h0028);
    twist <= 8'sh05;
    await(TORQ, 16'h0000);
    twist <= 8'sh14;
    i_power_ok <= 1'b0;
    await(HOLD, 16'h0000);
    i_power_ok <= 1'b1;
    await(HOLD, 16'h0001);
    wr(ADDR_INT_STATUS, 16'h0007);
    i_alarm <= 1'b1;
    await(HOLD, 16'h0000);
    rd_chk(ADDR_INT_STATUS, 16'h0002);
    rd_chk(ADDR_STATUS, 16'h0002);
    rd_chk(ADDR_ACTIVE, 16'h002d);
    $display("Test holding finished");
    close_out();
  end
endmodule : testbench
